// ===== stack_cpu_core_with_irq.sv
// 4-bit stack core with eight-level interrupt controller
`timescale 1ns/100ps
`default_nettype none
module stack_cpu_core_with_irq
  import stack_core_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [11:0] pmem_addr,
  input  wire logic [7:0]  pmem_data,
  output logic      [3:0]  io_addr,
  output logic      [3:0]  io_wdata,
  output logic             io_wr,
  output logic             io_rd,
  input  wire logic [3:0]  io_rdata,
  input  wire logic [7:0]  irq_req
);

////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [255:0][3:0] ram;
    logic [11:0]       instr_pointer;
    logic [7:0]        expr_stack_ptr;
    logic [7:0]        ret_stack_ptr;
    logic [7:0]        x;
    logic [7:0]        y;
    logic [3:0]        stack_head;
    logic [3:0]        flag_nibble;
    logic [7:0]        opcode;
    logic [7:0]        pending;
    logic [7:0]        active;
    logic [7:0]        req_hold;
    core_state_e       state;
    logic              phase;
    logic              run;
    logic              dph_wr;
    logic [7:0]        dph_addr;
    logic [31:0]       rdata;
  } core_s;

  core_s r;
  core_s next_r;

  // highest set bit: {valid, index}
  function automatic logic [3:0] top_level(input logic [7:0] v);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return top_level_ret(res);
  endfunction

  function automatic logic [3:0] top_level_ret(input logic [3:0] v);
    return v;
  endfunction

  // returns {flags, result}; a is head, b is second
  function automatic logic [7:0] alu(input logic [3:0] op,
                                     input logic [3:0] a,
                                     input logic [3:0] b,
                                     input logic [3:0] f);
    logic [4:0] s;
    logic [3:0] nf;
    logic [3:0] res;
    s   = 5'h00;
    nf  = f;
    res = a;
    case (op)
      ALU_ADD: begin
        s = {1'b0, b} + {1'b0, a};
        res = s[3:0];
        nf[FLAG_C] = s[4];
        nf[FLAG_B] = s[4];
      end
      ALU_SUB: begin
        s = {1'b0, b} - {1'b0, a};
        res = s[3:0];
        nf[FLAG_C] = s[4];
        nf[FLAG_B] = s[4];
      end
      ALU_AND, ALU_OR, ALU_XOR: begin
        res = (op == ALU_AND) ? (a & b) :
              (op == ALU_OR)  ? (a | b) : (a ^ b);
        nf[FLAG_B] = (res == 4'h0); // carry untouched
      end
      ALU_ROL: begin
        res = {a[2:0], f[FLAG_C]};
        nf[FLAG_C] = a[3];
        nf[FLAG_B] = a[3];
      end
      ALU_ROR: begin
        res = {f[FLAG_C], a[3:1]};
        nf[FLAG_C] = a[0];
        nf[FLAG_B] = a[0];
      end
      default: ;
    endcase
    return {nf, res};
  endfunction

////////////////////////////////////////////////////////////////////////
  logic       tick;
  logic       eligible;
  logic       is_io;
  logic [3:0] pend_hi;
  logic [3:0] act_hi;
  logic [3:0] grp;
  logic [3:0] sub;
  logic [3:0] second;

  assign grp       = r.opcode[7:4];
  assign sub       = r.opcode[3:0];
  assign second    = r.ram[r.expr_stack_ptr];
  assign tick      = r.phase & r.run;
  assign pend_hi   = top_level(r.pending & ~r.active);
  assign act_hi    = top_level(r.active);
  // a level is eligible only above every active level
  assign eligible  = r.flag_nibble[FLAG_I] & pend_hi[3] &
                     (~act_hi[3] | (pend_hi[2:0] > act_hi[2:0]));
  assign is_io     = (r.state == st_exec) & ~eligible &
                     ((grp == OPG_IN) | (grp == OPG_OUT));
  assign io_addr   = sub;
  assign io_wdata  = r.stack_head;
  assign io_wr     = tick & is_io & (grp == OPG_OUT);
  assign io_rd     = tick & is_io & (grp == OPG_IN);
  assign hrdata    = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  // table op borrows the program bus for one machine cycle
  assign pmem_addr = (r.state == st_table) ?
                     {r.instr_pointer[11:8], second, r.stack_head} :
                     r.instr_pointer;

////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        do_call;
    logic        do_return;
    logic [11:0] call_ret;
    logic [11:0] call_target;
    logic [7:0]  sp_up;
    logic [7:0]  sp_dn;
    logic [7:0]  ptr;
    logic [7:0]  res8;
    logic [7:0]  soft_set;
    do_call     = 1'b0;
    do_return   = 1'b0;
    call_ret    = r.instr_pointer;
    call_target = r.instr_pointer;
    sp_up       = r.expr_stack_ptr + ONE8;
    sp_dn       = r.expr_stack_ptr - ONE8;
    ptr         = 8'h00;
    res8        = 8'h00;
    soft_set    = 8'h00;
    next_r      = r;
    next_r.phase    = ~r.phase;
    next_r.req_hold = r.req_hold | irq_req;

    // ahb-lite slave, zero wait states
    next_r.dph_wr = 1'b0;
    if (r.dph_wr) begin
      if (r.dph_addr == REG_CTRL) begin
        next_r.run = hwdata[0];
      end
      if (r.dph_addr == REG_IRQ) begin
        soft_set = hwdata[7:0];
      end
    end
    if (hsel & hready & htrans[1]) begin
      next_r.dph_wr   = hwrite;
      next_r.dph_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          REG_CTRL:   next_r.rdata = {31'h0, r.run};
          REG_STATUS: next_r.rdata = {8'h0, r.opcode, r.flag_nibble,
                                      r.instr_pointer};
          REG_IRQ:    next_r.rdata = {16'h0, r.active, r.pending};
          REG_PTRS:   next_r.rdata = {r.y, r.x, r.ret_stack_ptr,
                                      r.expr_stack_ptr};
          default:    next_r.rdata = 32'h0;
        endcase
      end
    end

    if (tick) begin
      unique case (r.state)
        st_fill: begin
          next_r.opcode        = pmem_data;
          next_r.instr_pointer = r.instr_pointer + ONE12;
          next_r.state         = st_exec;
        end
        st_table: begin
          next_r.stack_head              = pmem_data[3:0];
          next_r.ram[r.expr_stack_ptr]   = pmem_data[7:4];
          next_r.state                   = st_fill;
        end
        st_sleep: begin
          if (|r.pending) begin
            next_r.state = st_exec;
          end
        end
        st_exec: begin
          if (eligible) begin
            // acknowledge: re-run the held opcode after return
            do_call     = 1'b1;
            call_ret    = r.instr_pointer - ONE12;
            call_target = IRQ_VECTOR[pend_hi[2:0]];
            next_r.active[pend_hi[2:0]] = 1'b1;
          end else begin
            // prefetched byte becomes the next opcode
            next_r.opcode        = pmem_data;
            next_r.instr_pointer = r.instr_pointer + ONE12;
            if (r.opcode[7:6] == OPG_SHORT_VECTOR_CALL) begin
              do_call     = 1'b1;
              call_target = {ZP_PAD, r.opcode[5:0], ZP_PAD};
            end else if (r.opcode[7:6] == OPG_LONG) begin
              next_r.state         = st_fill;
              call_ret             = r.instr_pointer + ONE12;
              next_r.instr_pointer = call_ret;
              call_target          = {sub, pmem_data};
              if (r.opcode[5:4] == LONG_JMP |
                  (r.opcode[5:4] == LONG_BR &
                   r.flag_nibble[FLAG_B])) begin
                next_r.instr_pointer = call_target;
              end
              do_call = (r.opcode[5:4] == LONG_CALL);
            end else begin
              unique case (grp)
                OPG_ALU: begin
                  res8 = alu(sub, r.stack_head, second,
                             r.flag_nibble);
                  next_r.flag_nibble = res8[7:4];
                  next_r.stack_head  = res8[3:0];
                  if (sub == ALU_DROP) begin
                    next_r.stack_head     = second;
                    next_r.expr_stack_ptr = sp_dn;
                  end else if (sub == ALU_DUP) begin
                    next_r.ram[sp_up]     = r.stack_head;
                    next_r.expr_stack_ptr = sp_up;
                  end else if (sub >= ALU_ADD && sub <= ALU_XOR) begin
                    next_r.expr_stack_ptr = sp_dn;
                  end
                end
                OPG_LIT, OPG_IN: begin
                  next_r.ram[sp_up]     = r.stack_head;
                  next_r.expr_stack_ptr = sp_up;
                  next_r.stack_head     = (grp == OPG_IN) ?
                                          io_rdata : sub;
                end
                OPG_OUT: begin
                  next_r.stack_head     = second;
                  next_r.expr_stack_ptr = sp_dn;
                end
                OPG_MEM: begin
                  ptr = sub[MEM_SEL_Y] ? r.y : r.x;
                  if (sub[MEM_PRE]) begin
                    ptr = ptr + ONE8;
                  end
                  if (sub[MEM_STORE]) begin
                    next_r.ram[ptr]       = r.stack_head;
                    next_r.stack_head     = second;
                    next_r.expr_stack_ptr = sp_dn;
                  end else begin
                    next_r.ram[sp_up]     = r.stack_head;
                    next_r.stack_head     = r.ram[ptr];
                    next_r.expr_stack_ptr = sp_up;
                  end
                  if (sub[MEM_POST]) begin
                    ptr = ptr - ONE8;
                  end
                  if (sub[MEM_SEL_Y]) begin
                    next_r.y = ptr;
                  end else begin
                    next_r.x = ptr;
                  end
                end
                OPG_PTR: begin
                  next_r.stack_head     = r.ram[sp_dn];
                  next_r.expr_stack_ptr = sp_dn - ONE8;
                  unique case (sub[1:0])
                    2'h0: next_r.x = {second, r.stack_head};
                    2'h1: next_r.y = {second, r.stack_head};
                    2'h2: next_r.expr_stack_ptr = {second, r.stack_head};
                    2'h3: next_r.ret_stack_ptr = {second, r.stack_head};
                  endcase
                end
                OPG_CTL: begin
                  case (sub)
                    OP_MASK_ALL: next_r.flag_nibble[FLAG_I] = 1'b0;
                    OP_UNMASK_ALL: next_r.flag_nibble[FLAG_I] = 1'b1;
                    OP_SLEEP: begin
                      next_r.flag_nibble[FLAG_I] = 1'b1;
                      next_r.state               = st_sleep;
                    end
                    OP_FLAG_SET: begin
                      next_r.flag_nibble[FLAG_B] = 1'b1;
                      next_r.flag_nibble[FLAG_C] = 1'b1;
                    end
                    OP_FLAG_TOG: next_r.flag_nibble[FLAG_B] =
                                   ~r.flag_nibble[FLAG_B];
                    OP_FLAG_LOAD: begin
                      next_r.flag_nibble    = r.stack_head & FLAG_MASK;
                      next_r.stack_head     = second;
                      next_r.expr_stack_ptr = sp_dn;
                    end
                    OP_RETURN: do_return = 1'b1;
                    OP_SVC_RETURN: begin
                      do_return = 1'b1;
                      if (act_hi[3]) begin
                        next_r.active[act_hi[2:0]]  = 1'b0;
                        next_r.pending[act_hi[2:0]] = 1'b0;
                      end
                    end
                    OP_SOFT_REQ: begin
                      soft_set = soft_set |
                                 {second, r.stack_head};
                      next_r.stack_head     = r.ram[sp_dn];
                      next_r.expr_stack_ptr = sp_dn - ONE8;
                    end
                    OP_TABLE: begin
                      next_r.opcode        = r.opcode;
                      next_r.instr_pointer = r.instr_pointer;
                      next_r.state         = st_table;
                    end
                    default: ;
                  endcase
                end
                default: ;
              endcase
            end
          end
        end
      endcase

      // return entry: pre-increment by four, last nibble left free
      if (do_call) begin
        next_r.ret_stack_ptr = r.ret_stack_ptr + RET_STEP;
        next_r.ram[r.ret_stack_ptr + RET_STEP]          = call_ret[11:8];
        next_r.ram[r.ret_stack_ptr + RET_STEP + ONE8]   = call_ret[7:4];
        next_r.ram[r.ret_stack_ptr + RET_STEP + ONE8 + ONE8] =
          call_ret[3:0];
        next_r.instr_pointer = call_target;
        next_r.state         = st_fill;
      end
      if (do_return) begin
        next_r.instr_pointer = {r.ram[r.ret_stack_ptr],
                                r.ram[r.ret_stack_ptr + ONE8],
                                r.ram[r.ret_stack_ptr + ONE8 + ONE8]};
        next_r.ret_stack_ptr = r.ret_stack_ptr - RET_STEP;
        next_r.state         = st_fill;
      end
      // sample requests except in io cycles; set wins over clear
      if (!is_io) begin
        next_r.pending  = next_r.pending | r.req_hold;
        next_r.req_hold = irq_req;
      end
    end
    next_r.pending = next_r.pending | soft_set;
  end

////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r        <= '0; // clears enable, pending, active
      r.opcode <= RST_OPCODE;
      r.instr_pointer <= RST_IP;
      r.run    <= RST_RUN;
    end else begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

// ===== stack_core_pkg.sv
// constants, encodings and types shared by the stack core
`default_nettype none
package stack_core_pkg;
  // reset values and step constants
  localparam logic [11:0] RST_IP     = 12'h000;
  localparam logic [7:0]  RST_OPCODE = 8'hc1;
  localparam logic        RST_RUN    = 1'b1;
  localparam logic [7:0]  RET_STEP   = 8'h04;
  localparam logic [7:0]  ONE8       = 8'h01;
  localparam logic [11:0] ONE12      = 12'h001;
  // flag_nibble bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_I = 2;
  localparam logic [3:0] FLAG_MASK = 4'h7;
  // zero page short call: vector = {pad, opcode[5:0], pad}
  localparam logic [2:0] ZP_PAD = 3'h0;
  // service vectors, level 0 lowest priority
  localparam logic [7:0][11:0] IRQ_VECTOR = {
    12'h1e0, 12'h1c0, 12'h180, 12'h140,
    12'h100, 12'h0c0, 12'h080, 12'h040};
  // opcode groups (high nibble; long and short vector call groups use the top two bits)
  localparam logic [3:0] OPG_ALU = 4'h0;
  localparam logic [3:0] OPG_LIT = 4'h1;
  localparam logic [3:0] OPG_MEM = 4'h2;
  localparam logic [3:0] OPG_PTR = 4'h3;
  localparam logic [3:0] OPG_IN  = 4'h4;
  localparam logic [3:0] OPG_OUT = 4'h5;
  localparam logic [3:0] OPG_CTL = 4'h6;
  localparam logic [1:0] OPG_LONG  = 2'h2;
  localparam logic [1:0] OPG_SHORT_VECTOR_CALL = 2'h3;
  localparam logic [1:0] LONG_JMP  = 2'h0;
  localparam logic [1:0] LONG_BR   = 2'h1;
  localparam logic [1:0] LONG_CALL = 2'h2;
  // alu group low nibble
  localparam logic [3:0] ALU_ADD  = 4'h1;
  localparam logic [3:0] ALU_SUB  = 4'h2;
  localparam logic [3:0] ALU_AND  = 4'h3;
  localparam logic [3:0] ALU_OR   = 4'h4;
  localparam logic [3:0] ALU_XOR  = 4'h5;
  localparam logic [3:0] ALU_ROL  = 4'h6;
  localparam logic [3:0] ALU_ROR  = 4'h7;
  localparam logic [3:0] ALU_DROP = 4'h8;
  localparam logic [3:0] ALU_DUP  = 4'h9;
  // memory group bit positions
  localparam int MEM_SEL_Y = 0;
  localparam int MEM_STORE = 1;
  localparam int MEM_PRE   = 2;
  localparam int MEM_POST  = 3;
  // control group low nibble
  localparam logic [3:0] OP_MASK_ALL   = 4'h0;
  localparam logic [3:0] OP_UNMASK_ALL = 4'h1;
  localparam logic [3:0] OP_SLEEP      = 4'h2;
  localparam logic [3:0] OP_FLAG_SET   = 4'h3;
  localparam logic [3:0] OP_FLAG_TOG   = 4'h4;
  localparam logic [3:0] OP_FLAG_LOAD  = 4'h5;
  localparam logic [3:0] OP_RETURN     = 4'h6;
  localparam logic [3:0] OP_SVC_RETURN = 4'h7;
  localparam logic [3:0] OP_SOFT_REQ   = 4'h8;
  localparam logic [3:0] OP_TABLE      = 4'h9;
  // ahb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ    = 8'h08;
  localparam logic [7:0] REG_PTRS   = 8'h0c;
  localparam logic       HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {
    st_exec, st_fill, st_table, st_sleep
  } core_state_e;
endpackage
`default_nettype wire

// ===== stack_core_properties.sv
// port-level assertions for the stack core
`timescale 1ns/100ps
`default_nettype none
module stack_core_properties
  import stack_core_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [11:0] pmem_addr,
  input wire logic [3:0]  io_addr,
  input wire logic [3:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && hready && htrans[1];
  //////////////////////////////////////////////////////////////////////////
  sequence bad_rd_s;
    take && !hwrite && haddr[7:0] > REG_PTRS;
  endsequence
  sequence stat_rd_s;
    take && !hwrite && haddr[7:0] == REG_STATUS;
  endsequence
  sequence halt_s;
    take && hwrite && haddr[7:0] == REG_CTRL ##1 !hwdata[0];
  endsequence
  sequence rst_rel_s;
    $rose(hresetn);
  endsequence
  //////////////////////////////////////////////////////////////////////////
  resp_okay_a: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  no_wait_a: assert property (hreadyout)
    else $error("wait state inserted");
  unmapped_zero_a: assert property (bad_rd_s |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  flag_pad_a: assert property (stat_rd_s |=> !hrdata[15])
    else $error("spare flag bit set");
  io_pulse_a: assert property (io_wr || io_rd |=> !io_wr && !io_rd)
    else $error("io strobe longer than one clock");
  io_excl_a: assert property (!(io_wr && io_rd))
    else $error("io read and write together");
  io_hold_a: assert property (io_wr |-> $stable(io_addr) && $stable(io_wdata))
    else $error("io address or data moved");
  cycle_hold_a: assert property (!$stable(pmem_addr) |=> $stable(pmem_addr))
    else $error("fetch address held one clock only");
  reset_call_a: assert property (rst_rel_s |-> ##[1:8] pmem_addr == 12'h008)
    else $error("no call to 008 after reset");
  halt_hold_a: assert property (halt_s |-> ##2 $stable(pmem_addr) [*4])
    else $error("core moved while halted");
endmodule
bind stack_cpu_core_with_irq stack_core_properties stack_core_properties_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pmem_addr(pmem_addr), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_wr(io_wr), .io_rd(io_rd));
`default_nettype wire

// ===== pmem_io_model.sv
// program memory and io peripheral model facing the core
`timescale 1ns/100ps
`default_nettype none
module pmem_io_model (
  input  wire logic        hclk,
  input  wire logic [11:0] pmem_addr,
  output logic      [7:0]  pmem_data,
  input  wire logic [3:0]  io_addr,
  input  wire logic [3:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [3:0]  gate,
  input  wire logic [3:0]  rnd,
  output logic      [3:0]  io_rdata
);
  logic [7:0] mem [4096];
  logic [3:0] regs [16];
  logic [3:0] pat = 4'h5;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    for (int i = 0; i < 16; i++) regs[i] = 4'h0;
  end
  // asynchronous program read
  assign pmem_data = mem[pmem_addr];
  always @(posedge hclk) begin
    pat <= ~pat + 4'h3;
    if (io_wr) regs[io_addr] <= io_wdata;
  end
  // bus not read: pattern changing every clock
  always_comb begin
    if (!io_rd) io_rdata = pat;
    else if (io_addr == 4'h2) io_rdata = gate;
    else if (io_addr == 4'h3) io_rdata = rnd;
    else io_rdata = regs[io_addr];
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the stack core
`timescale 1ns/100ps
`default_nettype none
module testbench
  import stack_core_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  irq_req = 8'h0;
  logic [3:0]  gate = 4'h0;
  logic [3:0]  rnd = 4'h0;
  logic        dph = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, io_wr, io_rd;
  wire  [11:0] pmem_addr;
  wire  [7:0]  pmem_data;
  wire  [3:0]  io_addr, io_wdata, io_rdata;
  int          miscompares = 0;
  int          num_checks = 0;
  int          seed = 32'h2d1bc6e4;
  logic [7:0]  io_q [$];
  logic [31:0] rd_q [$];
  logic [31:0] mk_q [$];
  logic [7:0]  prog [15] = '{8'h13, 8'h15, 8'h01, 8'h57, 8'h43, 8'h54,
    8'h60, 8'h42, 8'h10, 8'h04, 8'h90, 8'h0f, 8'h61, 8'h80, 8'h15};
  always #50 hclk = ~hclk;
  stack_cpu_core_with_irq stack_cpu_core_with_irq_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .irq_req(irq_req));
  pmem_io_model pmem_io_model_inst (
    .hclk(hclk), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .gate(gate), .rnd(rnd), .io_rdata(io_rdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      conclude;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    mk_q.push_back(m);
    rd_q.push_back(e & m);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (io_q.size() != 0 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (io_q.size() != 0) begin
      miscompares++;
      conclude;
    end
  endtask
  task automatic wait_pc(input logic [11:0] a, output int n);
    n = 0;
    while (pmem_addr !== a && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (pmem_addr !== a) begin
      miscompares++;
      conclude;
    end
  endtask
  task automatic pulse(input logic [7:0] v);
    irq_req <= v;
    @(posedge hclk);
    irq_req <= 8'h0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // read data taken at the end of each data phase
  always @(posedge hclk) begin
    if (dph && hreadyout === 1'b1 && rd_q.size() != 0)
      chk("hrdata", rd_q.pop_front(), hrdata & mk_q.pop_front());
    dph <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  always @(posedge hclk) begin
    if (io_wr === 1'b1 && io_q.size() == 0) begin
      miscompares++;
      $display("MISMATCH io_write expected none seen %h",
               {io_addr, io_wdata});
    end else if (io_wr === 1'b1) begin
      chk("io_write", {24'h0, io_q.pop_front()},
          {24'h0, io_addr, io_wdata});
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [11:0] v;
    logic [11:0] a;
    rnd <= 4'($random(seed));
    #1;
    for (int i = 0; i < 15; i++) pmem_io_model_inst.mem[12'h008 + i] = prog[i];
    for (int k = 0; k < 8; k++) begin
      v = IRQ_VECTOR[k];
      pmem_io_model_inst.mem[v] = {4'h1, 4'(k)};
      pmem_io_model_inst.mem[v + 12'h1] = 8'h5e;
      pmem_io_model_inst.mem[v + 12'h2] = 8'h67;
    end
    io_q.push_back({4'h7, 4'h8});
    io_q.push_back({4'h4, rnd});
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REG_IRQ, 32'hffff, 32'h0);
    rd(REG_CTRL, 32'h1, 32'h1);
    rd(8'h40, 32'hffffffff, 32'h0);
    rd(REG_PTRS, 32'hff00, 32'h0400);
    drain;
    $display("test reset done");
    rd(REG_STATUS, 32'h4000, 32'h0);
    pulse(8'h20);
    repeat (20) @(posedge hclk);
    rd(REG_IRQ, 32'hffff, 32'h0020);
    io_q.push_back({4'he, 4'h5});
    gate <= 4'($random(seed)) | 4'h1;
    drain;
    wait_pc(12'h015, n);
    rd(REG_IRQ, 32'hffff, 32'h0);
    rd(REG_STATUS, 32'h4000, 32'h4000);
    $display("test masked done");
    for (int k = 0; k < 8; k++) begin
      io_q.push_back({4'he, 4'(k)});
      if (k[0]) begin
        pulse(8'(1 << k));
        wait_pc(IRQ_VECTOR[k], n);
        chk("latency", 32'h1, {31'h0, n <= 10});
      end else begin
        xfer(1'b1, REG_IRQ, 32'h1 << k);
      end
      drain;
      wait_pc(12'h015, n);
    end
    $display("test levels done");
    io_q.push_back({4'he, 4'h6});
    io_q.push_back({4'he, 4'h2});
    pulse(8'h44);
    drain;
    wait_pc(12'h015, n);
    $display("test priority done");
    xfer(1'b1, REG_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    a = pmem_addr;
    repeat (6) @(posedge hclk);
    chk("halted_addr", {20'h0, a}, {20'h0, pmem_addr});
    xfer(1'b1, REG_CTRL, 32'h1);
    wait_pc(12'h016, n);
    $display("test halt done");
    conclude;
  end
endmodule
`default_nettype wire
